// >>> bench/far_peer.sv
// far side model: serial peer, loopback, external stream, monitor, link state
`timescale 1ns/1ns
`default_nettype none
module far_peer (
  // clock
  input wire logic aclk,
  // scenario controls
  input wire logic active,
  input wire logic hold_lvl,
  input wire logic ext_lvl,
  input wire logic [7:0] mon_lvl,
  input wire logic lu_lvl,
  // pins toward the block
  output logic line_serial_in = 1'b0,
  output logic loopback_serial_in = 1'b1,
  output logic external_serial_in = 1'b0,
  output logic [7:0] monitor_feedback = 8'h80,
  output logic link_unusable = 1'b0
);
  // line toggles every cycle while a signal is present, else rests quiet
  always @(posedge aclk) begin
    line_serial_in <= active ? !line_serial_in : hold_lvl;
    loopback_serial_in <= !hold_lvl;
    external_serial_in <= ext_lvl;
    monitor_feedback <= mon_lvl;
    link_unusable <= lu_lvl;
  end
endmodule : far_peer
`default_nettype wire

// >>> bench/serdes_path_select_test.sv
// self-checking bench of the serial path select and laser safety block
`timescale 1ns/1ns
`default_nettype none
`include "serdes_cfg.svh"
module serdes_path_select_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rx_lock_source;
  logic internal_stream = 1'b0;
  logic cable_serial_out, laser_serial_out, laser_drive_enable;
  logic monitor_force_low, fault_flag, rx_rate_high, equalizer_in_path;
  logic rx_serial_data, signal_loss_a, signal_loss_b;
  logic line_serial_in, loopback_serial_in, external_serial_in;
  logic link_unusable;
  logic [7:0] monitor_feedback;
  logic active = 1'b0, hold_lvl = 1'b0, ext_lvl = 1'b0;
  logic lu = 1'b0, flt = 1'b0, loss_e = 1'b1;
  logic [7:0] mon = 8'h80, ctl = 8'h70;
  logic [2:0] rows [5] = '{3'b011, 3'b100, 3'b101, 3'b111, 3'b110};
  logic [33:0] exp_q [$];
  int n_errors = 0, check_count = 0, cyc = 0;
  event pin_ev;

  serdes_path_select #(.FAULT_CYCLES(20), .BYTE_DIV(1)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .internal_stream, .external_serial_in,
    .cable_serial_out, .laser_serial_out, .monitor_feedback,
    .laser_drive_enable, .monitor_force_low, .fault_flag, .line_serial_in,
    .loopback_serial_in, .link_unusable, .rx_rate_high, .equalizer_in_path,
    .rx_serial_data, .rx_lock_source, .signal_loss_a, .signal_loss_b);

  far_peer peer (.aclk, .active, .hold_lvl, .ext_lvl, .mon_lvl(mon),
    .lu_lvl(lu), .line_serial_in, .loopback_serial_in, .external_serial_in,
    .monitor_feedback, .link_unusable);

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 aclk = !aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare one answer with the oldest note
  task automatic take(input logic [33:0] act);
    logic [33:0] e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
    check_count++;
    if (act !== e) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, act, e);
    end
  endtask : take

  // result watcher: bus answers and pin snapshots
  always @(posedge aclk) begin
    if (rvalid && rready) take({rresp, rdata});
    if (bvalid && bready) take({bresp, 32'h0});
  end

  always @(pin_ev) take({22'h0, cable_serial_out, laser_serial_out,
    laser_drive_enable, fault_flag, monitor_force_low, rx_rate_high,
    equalizer_in_path, rx_serial_data, rx_lock_source, signal_loss_a,
    signal_loss_b});

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: each channel held until its own ready
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    exp_q.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  task automatic setc(input logic [7:0] c);
    ctl = c;
    wr(`ADDR_CTRL, c, `RESP_OKAY);
  endtask : setc

  ////////////////////////////////////////////////////////////////////////////
  // expected pins from control byte and far side state
  function automatic logic pick(input logic [1:0] s);
    return s == 2'h1 ? internal_stream : s == 2'h2 ? ext_lvl : 1'b0;
  endfunction : pick

  function automatic logic [11:0] exp_vec();
    logic [3:0] rt;
    logic on;
    // {cable, laser} source: 0 none, 1 internal, 2 external
    case ({ctl[0], ctl[1], ctl[2]})
      3'h0, 3'h5: rt = 4'h1;
      3'h1: rt = 4'h0;
      3'h2: rt = 4'h5;
      3'h6: rt = 4'h6;
      default: rt = 4'h4;
    endcase
    on = !ctl[6] && ctl[7] && !flt;
    return {pick(rt[3:2]), on && pick(rt[1:0]), on, flt, flt, ctl[3],
      !ctl[4], ctl[2] ? !hold_lvl : hold_lvl,
      !ctl[5] ? 2'h0 : ctl[2] ? 2'h2 : lu ? 2'h0 : 2'h1, loss_e, loss_e};
  endfunction : exp_vec

  // wait, then note and snapshot the pins at a settled point
  task automatic chk(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
    exp_q.push_back({22'h0, exp_vec()});
    ->pin_ev;
  endtask : chk

  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(56200));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_CTRL, {`RESP_OKAY, 24'h0, `CTRL_RESET});
    rd(`ADDR_NOMINAL, {`RESP_OKAY, 24'h0, `NOMINAL_RESET});
    wr(`ADDR_STATUS, 8'hff, `RESP_OKAY);
    rd(`ADDR_STATUS, {`RESP_OKAY, 32'h0e});
    wr(12'h00c, 8'h5a, `RESP_SLVERR);
    rd(12'h00c, {`RESP_SLVERR, 32'h0});
    // every route code with random levels, rate and equalizer bits
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      internal_stream <= 1'($urandom);
      ext_lvl <= 1'($urandom);
      hold_lvl <= 1'($urandom);
      setc({3'b101, 2'($urandom), i[0], i[1], i[2]});
      chk(8);
    end
    // laser enable over both control levels
    for (int j = 0; j < 4; j++) begin
      setc({j[1], j[0], 6'h20});
      chk(2);
    end
    // monitor just inside, then just outside the window
    setc(8'ha0);
    @(posedge aclk);
    mon <= 8'h8c;
    chk(40);
    @(posedge aclk);
    mon <= 8'h73;
    chk(10);
    flt = 1;
    chk(30);
    @(posedge aclk);
    mon <= 8'h80;
    chk(30);
    setc(8'he0);
    flt = 0;
    chk(2);
    // signal loss with loopback selected and steady
    setc(8'ha4);
    @(posedge aclk);
    active <= 1'b1;
    loss_e = 0;
    chk(10);
    @(posedge aclk);
    active <= 1'b0;
    chk(3);
    loss_e = 1;
    chk(8);
    // reference lock held long enough, then the lock table
    setc(8'h00);
    chk(25000);
    for (int k = 0; k < 5; k++) begin
      @(posedge aclk);
      lu <= rows[k][0];
      setc({2'b0, rows[k][2], 2'b0, rows[k][1], 2'b0});
      chk(5);
    end
    results();
  end
endmodule : serdes_path_select_test
`default_nettype wire

// >>> core/_unused_placeholder_never.sv
// empty source unit, holds no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> core/fault_timer.sv
// monitor fault timer with latched fault and laser latch-off
`timescale 1ns/1ns
`default_nettype none
`include "serdes_cfg.svh"
module fault_timer #(
  parameter int FAULT_CYCLES = `FAULT_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // window result and laser-on control
  input wire logic out_of_window,
  input wire logic laser_on_n,
  // latched fault
  output logic fault
);
  localparam int CW = $clog2(FAULT_CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic fault;
  } ft_state_t;
  ft_state_t r;
  ft_state_t next_r;

  // elapsed time while out of window, fault latches until laser-on reset
  always_comb begin
    next_r = r;
    if (laser_on_n) begin
      next_r = '0;
    end else if (!r.fault) begin
      if (out_of_window) begin
        next_r.cnt = r.cnt + CW'(1);
        next_r.fault = (r.cnt == CW'(FAULT_CYCLES - 1));
      end else begin
        next_r.cnt = '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fault = r.fault;

  property p_fault_time;
    @(posedge aclk) disable iff (!aresetn)
      $rose(fault) |-> $past(r.cnt) == CW'(FAULT_CYCLES - 1);
  endproperty
  a_fault_time: assert property (p_fault_time)
    else $error("fault flagged before the fault time elapsed");

  property p_fault_hold;
    @(posedge aclk) disable iff (!aresetn)
      fault && !laser_on_n |=> fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault released without laser-on reset");

  property p_fault_clear;
    @(posedge aclk) disable iff (!aresetn)
      laser_on_n |=> !fault && r.cnt == '0;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("laser-on reset did not clear fault timer");
endmodule : fault_timer
`default_nettype wire

// >>> core/loss_detect.sv
// signal loss detector on the synchronised line input
`timescale 1ns/1ns
`default_nettype none
`include "serdes_cfg.svh"
module loss_detect #(
  parameter int LOSS_BYTES = `LOSS_BYTES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // byte rate enable and line level
  input wire logic byte_tick,
  input wire logic line_level,
  // loss flag
  output logic loss
);
  typedef struct packed {
    logic prev;
    logic [3:0] cnt;
    logic loss;
  } ld_state_t;
  ld_state_t r;
  ld_state_t next_r;

  // count quiet byte ticks, any edge restarts the count
  always_comb begin
    next_r = r;
    next_r.prev = line_level;
    if (line_level != r.prev) begin
      next_r.cnt = 4'h0;
    end else if (byte_tick && r.cnt != 4'(LOSS_BYTES)) begin
      next_r.cnt = r.cnt + 4'h1;
    end
    next_r.loss = (next_r.cnt == 4'(LOSS_BYTES));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign loss = r.loss;

  property p_loss_count;
    @(posedge aclk) disable iff (!aresetn)
      loss |-> r.cnt == 4'(LOSS_BYTES);
  endproperty
  a_loss_count: assert property (p_loss_count)
    else $error("loss flag without four quiet byte ticks");

  property p_loss_edge;
    @(posedge aclk) disable iff (!aresetn)
      (line_level != r.prev) |=> !loss;
  endproperty
  a_loss_edge: assert property (p_loss_edge)
    else $error("loss flag kept across a line transition");
endmodule : loss_detect
`default_nettype wire

// >>> core/serdes_cfg.svh
// constants of the serial path select and laser safety block
`ifndef SERDES_CFG_SVH
`define SERDES_CFG_SVH
// register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_NOMINAL 12'h004
`define ADDR_STATUS 12'h008
// control and nominal register reset values
`define CTRL_RESET 8'h70
`define NOMINAL_RESET 8'h80
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// timing
`define CLK_MHZ 50
`define FAULT_TIME_US 2000
`define FAULT_CYCLES (`FAULT_TIME_US * `CLK_MHZ)
`define WINDOW_PCT 10
`define LOSS_BYTES 4
`define BYTE_DIV 1
`endif

// >>> core/serdes_path_select.sv
// serial path select, laser safety and receive lock control
`timescale 1ns/1ns
`default_nettype none
`include "serdes_cfg.svh"
module serdes_path_select
  import serdes_pkg::*;
#(
  parameter int FAULT_CYCLES = `FAULT_CYCLES,
  parameter int BYTE_DIV = `BYTE_DIV
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // transmit streams
  input wire logic internal_stream,
  input wire logic external_serial_in,
  output logic cable_serial_out,
  output logic laser_serial_out,
  // laser safety
  input wire logic [7:0] monitor_feedback,
  output logic laser_drive_enable,
  output logic monitor_force_low,
  output logic fault_flag,
  // receive side
  input wire logic line_serial_in,
  input wire logic loopback_serial_in,
  input wire logic link_unusable,
  output logic rx_rate_high,
  output logic equalizer_in_path,
  output logic rx_serial_data,
  output logic [1:0] rx_lock_source,
  output logic signal_loss_a,
  output logic signal_loss_b
);
  typedef struct packed {
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    ctrl_t ctrl;
    logic [7:0] nominal;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] div_cnt;
    logic byte_tick;
    lock_t lock;
    logic cable_out;
    logic laser_out;
    logic rx_data;
    logic [7:0] mon_prev;
    logic [7:0] mon_ok;
  } state_t;
  state_t r;
  state_t next_r;

  tx_route_t route;
  logic ext_s;
  logic line_s;
  logic loop_s;
  logic unuse_s;
  logic [7:0] mon_s;
  logic fault;
  logic out_of_window;
  logic [2:0] code;

  //////////////////////////////////////////////////////////////////////
  // synchronised pin levels, read from the second stage; monitor word from the agreed copy mon_ok
  assign ext_s = r.pin_s2[0];
  assign line_s = r.pin_s2[1];
  assign loop_s = r.pin_s2[2];
  assign unuse_s = r.pin_s2[3];
  assign mon_s = r.mon_ok;
  assign code = {r.ctrl.tx_route_sel_a, r.ctrl.tx_route_sel_b,
                 r.ctrl.wrap_select};
  assign route = route_of(code);
  assign out_of_window = off_window(mon_s, r.nominal);

  // driver on only with laser-on low, power high and no fault
  assign laser_drive_enable = !r.ctrl.laser_on_n &&
                              r.ctrl.laser_power_enable &&
                              !fault;

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    next_r.pin_s1 = {monitor_feedback, link_unusable, loopback_serial_in,
                     line_serial_in, external_serial_in};
    next_r.pin_s2 = r.pin_s1;
    // monitor word taken only when two samples agree, so no torn word
    next_r.mon_prev = r.pin_s2[11:4];
    if (r.pin_s2[11:4] == r.mon_prev) next_r.mon_ok = r.pin_s2[11:4];

    // byte rate enable for the loss detectors
    if (r.div_cnt == 8'(BYTE_DIV - 1)) begin
      next_r.div_cnt = 8'h00;
      next_r.byte_tick = 1'b1;
    end else begin
      next_r.div_cnt = r.div_cnt + 8'h01;
      next_r.byte_tick = 1'b0;
    end

    // transmit routing
    next_r.cable_out = (route.cable == SRC_INTERNAL) && internal_stream;
    unique case (route.laser)
      SRC_INTERNAL: next_r.laser_out = internal_stream;
      SRC_EXTERNAL: next_r.laser_out = ext_s;
      SRC_NONE: next_r.laser_out = 1'b0;
      default: next_r.laser_out = 1'b0;
    endcase
    if (!laser_drive_enable) begin
      next_r.laser_out = 1'b0;
    end

    // receive input select
    next_r.rx_data = r.ctrl.wrap_select ? loop_s : line_s;

    // lock source state machine
    unique case (r.lock)
      LOCK_REF: begin
        if (r.ctrl.ref_lock_n) begin
          next_r.lock = r.ctrl.wrap_select ? LOCK_LOOP :
                        (unuse_s ? LOCK_REF : LOCK_LINE);
        end
      end
      LOCK_LINE: begin
        next_r.lock = !r.ctrl.ref_lock_n ? LOCK_REF :
                      r.ctrl.wrap_select ? LOCK_LOOP :
                      (unuse_s ? LOCK_REF : LOCK_LINE);
      end
      LOCK_LOOP: begin
        if (!r.ctrl.ref_lock_n) begin
          next_r.lock = LOCK_REF;
        end else if (!r.ctrl.wrap_select) begin
          next_r.lock = unuse_s ? LOCK_REF : LOCK_LINE;
        end
      end
      default: next_r.lock = LOCK_REF;
    endcase

    // axi write: address and data in either order
    if (awvalid && awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `RESP_OKAY;
      unique case ({r.aw_addr[11:2], 2'b00})
        `ADDR_CTRL: begin
          if (r.w_strb[0]) next_r.ctrl = ctrl_t'(r.w_data[7:0]);
        end
        `ADDR_NOMINAL: begin
          if (r.w_strb[0]) next_r.nominal = r.w_data[7:0];
        end
        `ADDR_STATUS: next_r.bresp = `RESP_OKAY;
        default: next_r.bresp = `RESP_SLVERR;
      endcase
    end

    // axi read
    if (arvalid && arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `RESP_OKAY;
      unique case ({araddr[11:2], 2'b00})
        `ADDR_CTRL: next_r.rdata = {24'h000000, r.ctrl};
        `ADDR_NOMINAL: next_r.rdata = {24'h000000, r.nominal};
        `ADDR_STATUS: next_r.rdata = {25'h0000000, unuse_s,
                                      laser_drive_enable, r.lock,
                                      signal_loss_b, signal_loss_a,
                                      fault};
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl <= ctrl_t'(`CTRL_RESET);
      r.nominal <= `NOMINAL_RESET;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timed fault and latch-off
  fault_timer #(
    .FAULT_CYCLES(FAULT_CYCLES)
  ) u_fault (
    .aclk(aclk),
    .aresetn(aresetn),
    .out_of_window(out_of_window),
    .laser_on_n(r.ctrl.laser_on_n),
    .fault(fault)
  );

  // loss detectors see the line input only, ahead of the equalizer
  loss_detect u_loss_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .byte_tick(r.byte_tick),
    .line_level(line_s),
    .loss(signal_loss_a)
  );

  loss_detect u_loss_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .byte_tick(r.byte_tick),
    .line_level(line_s),
    .loss(signal_loss_b)
  );

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign awready = !r.aw_held;
  assign wready = !r.w_held;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = !r.rvalid;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign cable_serial_out = r.cable_out;
  assign laser_serial_out = r.laser_out;
  assign fault_flag = fault;
  assign monitor_force_low = fault;
  assign rx_rate_high = r.ctrl.rate_select;
  assign equalizer_in_path = !r.ctrl.equalizer_enable_n;
  assign rx_serial_data = r.rx_data;
  assign rx_lock_source = r.lock;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_route_off;
    @(posedge aclk) disable iff (!aresetn)
      code == 3'h1 |=> !cable_serial_out && !laser_serial_out;
  endproperty
  a_route_off: assert property (p_route_off)
    else $error("code 1 drove an output");

  property p_route_ext;
    @(posedge aclk) disable iff (!aresetn)
      code == 3'h6 && laser_drive_enable |=>
        laser_serial_out == $past(ext_s) &&
        cable_serial_out == $past(internal_stream);
  endproperty
  a_route_ext: assert property (p_route_ext)
    else $error("code 6 routing wrong");

  property p_laser_off;
    @(posedge aclk) disable iff (!aresetn)
      (r.ctrl.laser_on_n || !r.ctrl.laser_power_enable) |=>
        !laser_serial_out;
  endproperty
  a_laser_off: assert property (p_laser_off)
    else $error("laser data while driver disabled");

  property p_rx_sel;
    @(posedge aclk) disable iff (!aresetn)
      r.ctrl.wrap_select |=> rx_serial_data == $past(loop_s);
  endproperty
  a_rx_sel: assert property (p_rx_sel)
    else $error("wrap did not select loopback input");

  property p_lock_ref;
    @(posedge aclk) disable iff (!aresetn)
      !r.ctrl.ref_lock_n |=> rx_lock_source == LOCK_REF;
  endproperty
  a_lock_ref: assert property (p_lock_ref)
    else $error("not on reference lock while ref_lock_n low");

  property p_lock_unuse;
    @(posedge aclk) disable iff (!aresetn)
      $rose(unuse_s) && rx_lock_source == LOCK_LINE &&
        r.ctrl.ref_lock_n && !r.ctrl.wrap_select |=>
        rx_lock_source == LOCK_REF;
  endproperty
  a_lock_unuse: assert property (p_lock_unuse)
    else $error("link_unusable did not return to reference lock");

  property p_lock_loop;
    @(posedge aclk) disable iff (!aresetn)
      r.ctrl.ref_lock_n && r.ctrl.wrap_select |=>
        rx_lock_source == LOCK_LOOP;
  endproperty
  a_lock_loop: assert property (p_lock_loop)
    else $error("wrap mode left loopback lock");
endmodule : serdes_path_select
`default_nettype wire

// >>> core/serdes_pkg.sv
// types shared by the serial path select and laser safety block
`include "serdes_cfg.svh"
package serdes_pkg;
  // software controlled pins, msb first as in the control register
  typedef struct packed {
    logic laser_power_enable;
    logic laser_on_n;
    logic ref_lock_n;
    logic equalizer_enable_n;
    logic rate_select;
    logic wrap_select;
    logic tx_route_sel_b;
    logic tx_route_sel_a;
  } ctrl_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_INTERNAL = 2'b01,
    SRC_EXTERNAL = 2'b10
  } src_t;

  typedef struct packed {
    src_t cable;
    src_t laser;
  } tx_route_t;

  typedef enum logic [1:0] {
    LOCK_REF = 2'b00,
    LOCK_LINE = 2'b01,
    LOCK_LOOP = 2'b10
  } lock_t;

  // select code {sel_a, sel_b, wrap} to output sources
  function automatic tx_route_t route_of(input logic [2:0] code);
    tx_route_t t;
    t = '{cable: SRC_NONE, laser: SRC_NONE};
    unique case (code)
      3'h0: t.laser = SRC_INTERNAL;
      3'h1: t = '{cable: SRC_NONE, laser: SRC_NONE};
      3'h2: t = '{cable: SRC_INTERNAL, laser: SRC_INTERNAL};
      3'h3: t.cable = SRC_INTERNAL;
      3'h4: t.cable = SRC_INTERNAL;
      3'h5: t.laser = SRC_INTERNAL;
      3'h6: t = '{cable: SRC_INTERNAL, laser: SRC_EXTERNAL};
      3'h7: t.cable = SRC_INTERNAL;
    endcase
    return t;
  endfunction : route_of

  // true when the monitor level is more than the window off nominal
  function automatic logic off_window(input logic [7:0] m,
                                      input logic [7:0] nom);
    logic [7:0] d;
    logic [14:0] lhs;
    logic [14:0] rhs;
    d = (m > nom) ? 8'(m - nom) : 8'(nom - m);
    lhs = 15'(d) * 15'd100;
    rhs = 15'(nom) * 15'(`WINDOW_PCT);
    return lhs > rhs;
  endfunction : off_window
endpackage : serdes_pkg
